// ===== power_down_map.svh
// Register indices, field positions, patterns and reset values.
`ifndef POWER_DOWN_MAP_SVH
`define POWER_DOWN_MAP_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define ICC_INDEX 6'h01
`define PDC_INDEX 6'h02
`define STS_INDEX 6'h08

// ==========================================================================
// Reset values
`define ICC_RESET 8'h00
`define PDC_RESET 8'h00

// ==========================================================================
// Interface clock control fields
`define PIN_B_CLKOUT_BIT 2
`define PIN_C_INV_BIT 1

// ==========================================================================
// Power-down control fields
`define TXA_HI 7
`define TXA_LO 5
`define TXD_BIT 4
`define RXD_BIT 3
`define PLL_PD_BIT 2
`define PLL_DISC_BIT 1

// ==========================================================================
// Transmit analog power-down patterns
`define TXA_A_OFF 3'h4
`define TXA_B_OFF 3'h2
`define TXA_ALL_OFF 3'h7

// ==========================================================================
// Status fields
`define STS_LOCK_BIT 0
`define STS_SEL_PLL_BIT 1
`define STS_TXCLK_BIT 2
`define STS_RXCLK_BIT 3
`define STS_DACA_BIT 4
`define STS_DACB_BIT 5
`define STS_SUPPORT_BIT 6
`define STS_BIAS_BIT 7

`endif

// ===== power_down_pkg.sv
// Types shared by the power-down and clock-out control logic.
package power_down_pkg;

  typedef enum logic [1:0] {
    TX_ALL_ON,
    TX_A_OFF,
    TX_B_OFF,
    TX_ALL_OFF
  } tx_mode_t;

  typedef struct packed {
    logic bias_on;
    logic support_off;
    logic dac_b_off;
    logic dac_a_off;
  } tx_analog_t;

  typedef struct packed {
    logic [9:0] chan_b;
    logic [9:0] chan_a;
  } tx_sample_t;

endpackage

// ===== power_down_and_clock_out_control.sv
// Power-down and interface clock-out control with an APB register slave.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "power_down_map.svh"

// Overview of operation
// [R1] Clock-out bit drives pin B clock, inverted full-duplex
// [R2] Invert bit inverts clock on pin C
// [R3] Patterns 100/010 silence channel A/B output
// [R4] Pattern 111 silences both, support circuitry off
// [R5] DAC bias stays on for fast recovery
// [R6] Transmit digital bit resets low, gates clocks
// [R7] Transmit outputs hold last values while down
// [R8] Receive digital bit powers down receive section
// [R9] PLL bit forces multiplier into power-down
// [R10] Partner supplies fastest clock while PLL down
// [R11] Disconnect removes PLL output, PLL keeps locking
module power_down_and_clock_out_control #(
  parameter int ADDR_W = 8
) (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock sources, sampled as levels
  input wire logic reference_clock_input,
  input wire logic pll_clock_in,
  input wire logic pll_locked,
  input wire logic full_duplex,
  // Interface clock pins
  output logic aux_interface_pin_b_out,
  output logic aux_interface_pin_b_oe,
  output logic aux_interface_pin_c_out,
  // Clock path
  output logic core_clock,
  output logic pll_power_down,
  output logic pll_output_connected,
  // Transmit path
  input wire logic tx_valid,
  input wire power_down_pkg::tx_sample_t tx_sample,
  output power_down_pkg::tx_sample_t tx_hold,
  output logic tx_clock_enable,
  output power_down_pkg::tx_analog_t tx_analog,
  // Receive path
  output logic rx_clock_enable
);

  // ========================================================================
  // Elaboration checks
  if (ADDR_W < 8)
  begin : g_addr_check
    $error("ADDR_W must be at least 8");
  end

  // ========================================================================
  // Registers and decode
  logic [7:0] icc_r;
  logic [7:0] pdc_r;
  logic [7:0] status;
  logic [5:0] word_index;
  logic upper_zero;
  logic hit_icc;
  logic hit_pdc;
  logic hit_sts;
  logic mapped;
  logic setup;
  logic access;
  logic wr_lane0;
  logic [31:0] rd_value;

  assign word_index = paddr[7:2];
  assign upper_zero = (paddr >> 8) == '0;
  assign hit_icc = upper_zero && (word_index == `ICC_INDEX);
  assign hit_pdc = upper_zero && (word_index == `PDC_INDEX);
  assign hit_sts = upper_zero && (word_index == `STS_INDEX);
  assign mapped = hit_icc || hit_pdc || hit_sts;
  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign wr_lane0 = access && pwrite && pstrb[0] && !pslverr;

  always_comb
  begin
    rd_value = 32'h0000_0000;
    if (hit_icc)
    begin
      rd_value = {24'h00_0000, icc_r};
    end
    else if (hit_pdc)
    begin
      rd_value = {24'h00_0000, pdc_r};
    end
    else if (hit_sts)
    begin
      rd_value = {24'h00_0000, status};
    end
  end

  // ========================================================================
  // APB handshake: no wait states, answer prepared in the setup cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup;
      if (setup)
      begin
        pslverr <= !mapped || (pwrite && hit_sts);
        prdata <= pwrite ? 32'h0000_0000 : rd_value;
      end
      else if (access)
      begin
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ========================================================================
  // Interface clock control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      icc_r <= `ICC_RESET;
    end
    else if (wr_lane0 && hit_icc)
    begin
      icc_r <= pwdata[7:0];
    end
  end

  // ========================================================================
  // Power-down control register, all fields low after reset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pdc_r <= `PDC_RESET; // R6
    end
    else if (wr_lane0 && hit_pdc)
    begin
      pdc_r <= pwdata[7:0];
    end
  end

  // ========================================================================
  // Clock path selection
  logic pll_pd_bit;
  logic pll_disc_bit;
  logic sel_pll;
  logic clk_mux;

  assign pll_pd_bit = pdc_r[`PLL_PD_BIT];
  assign pll_disc_bit = pdc_r[`PLL_DISC_BIT];
  // The reference input alone feeds the clock path when the PLL is down.
  assign sel_pll = !pll_pd_bit && !pll_disc_bit; // R10 R11
  assign clk_mux = sel_pll ? pll_clock_in : reference_clock_input;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      core_clock <= 1'b0;
      pll_power_down <= 1'b0;
      pll_output_connected <= 1'b0;
    end
    else
    begin
      core_clock <= clk_mux;
      pll_power_down <= pll_pd_bit; // R9
      // Disconnect alone leaves the PLL powered so it keeps lock.
      pll_output_connected <= sel_pll; // R11
    end
  end

  // ========================================================================
  // Interface clock pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      aux_interface_pin_b_out <= 1'b0;
      aux_interface_pin_b_oe <= 1'b0;
      aux_interface_pin_c_out <= 1'b0;
    end
    else
    begin
      aux_interface_pin_b_oe <= icc_r[`PIN_B_CLKOUT_BIT]; // R1
      if (icc_r[`PIN_B_CLKOUT_BIT])
      begin
        aux_interface_pin_b_out <= clk_mux ^ full_duplex; // R1
      end
      else
      begin
        aux_interface_pin_b_out <= 1'b0;
      end
      aux_interface_pin_c_out <= clk_mux ^ icc_r[`PIN_C_INV_BIT]; // R2
    end
  end

  // ========================================================================
  // Transmit analog power-down decode
  power_down_pkg::tx_mode_t tx_mode;
  power_down_pkg::tx_analog_t tx_analog_nxt;

  always_comb
  begin
    case (pdc_r[`TXA_HI:`TXA_LO])
      `TXA_A_OFF: tx_mode = power_down_pkg::TX_A_OFF; // R3
      `TXA_B_OFF: tx_mode = power_down_pkg::TX_B_OFF; // R3
      `TXA_ALL_OFF: tx_mode = power_down_pkg::TX_ALL_OFF; // R4
      default: tx_mode = power_down_pkg::TX_ALL_ON;
    endcase
  end

  always_comb
  begin
    tx_analog_nxt = '0;
    tx_analog_nxt.bias_on = 1'b1; // R5
    case (tx_mode)
      power_down_pkg::TX_A_OFF:
      begin
        tx_analog_nxt.dac_a_off = 1'b1; // R3
      end
      power_down_pkg::TX_B_OFF:
      begin
        tx_analog_nxt.dac_b_off = 1'b1; // R3
      end
      power_down_pkg::TX_ALL_OFF:
      begin
        tx_analog_nxt.dac_a_off = 1'b1; // R4
        tx_analog_nxt.dac_b_off = 1'b1; // R4
        tx_analog_nxt.support_off = 1'b1; // R4
      end
      default:
      begin
        tx_analog_nxt.dac_a_off = 1'b0;
      end
    endcase
  end

  // Recovery takes a single cycle because the bias stays on outside reset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_analog <= '0;
    end
    else
    begin
      tx_analog <= tx_analog_nxt; // R5
    end
  end

  // ========================================================================
  // Transmit digital section
  logic txd_bit;

  assign txd_bit = pdc_r[`TXD_BIT];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_clock_enable <= 1'b0;
    end
    else
    begin
      tx_clock_enable <= !txd_bit; // R6
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_hold <= '0;
    end
    else if (tx_valid && !txd_bit)
    begin
      tx_hold <= tx_sample; // R7
    end
  end

  // ========================================================================
  // Receive digital section
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_clock_enable <= 1'b0;
    end
    else
    begin
      rx_clock_enable <= !pdc_r[`RXD_BIT]; // R8
    end
  end

  // ========================================================================
  // Status word
  always_comb
  begin
    status = 8'h00;
    status[`STS_LOCK_BIT] = pll_locked && !pll_power_down;
    status[`STS_SEL_PLL_BIT] = pll_output_connected;
    status[`STS_TXCLK_BIT] = tx_clock_enable;
    status[`STS_RXCLK_BIT] = rx_clock_enable;
    status[`STS_DACA_BIT] = tx_analog.dac_a_off;
    status[`STS_DACB_BIT] = tx_analog.dac_b_off;
    status[`STS_SUPPORT_BIT] = tx_analog.support_off;
    status[`STS_BIAS_BIT] = tx_analog.bias_on;
  end

endmodule
`default_nettype wire

// ===== power_down_chk.sv
// Port checker for the power-down and clock-out control block.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Checker
module power_down_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Watched ports
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic full_duplex,
  input wire logic reference_clock_input,
  input wire logic pll_clock_in,
  input wire logic aux_interface_pin_b_out,
  input wire logic aux_interface_pin_b_oe,
  input wire logic aux_interface_pin_c_out,
  input wire logic core_clock,
  input wire logic pll_power_down,
  input wire logic pll_output_connected,
  input wire power_down_pkg::tx_sample_t tx_hold,
  input wire logic tx_clock_enable,
  input wire power_down_pkg::tx_analog_t tx_analog,
  input wire logic rx_clock_enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_wait_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  pin_b_a: assert property (aux_interface_pin_b_oe |->
    aux_interface_pin_b_out == (core_clock ^ $past(full_duplex)))
    else $error("pin b clock wrong");
  pin_b_idle_a: assert property (!aux_interface_pin_b_oe |->
    !aux_interface_pin_b_out) else $error("pin b driven while off");
  pin_c_a: assert property (presetn && $past(presetn) &&
    !$past(psel && penable && pready && pwrite, 2) |->
    $stable(aux_interface_pin_c_out ^ core_clock))
    else $error("pin c inversion changed");
  support_off_a: assert property (tx_analog.support_off |->
    tx_analog.dac_a_off && tx_analog.dac_b_off)
    else $error("support off with an output on");
  bias_on_a: assert property (presetn && $past(presetn) |->
    tx_analog.bias_on) else $error("bias current off");
  reset_clk_a: assert property ($rose(presetn) |=>
    tx_clock_enable && rx_clock_enable) else $error("clocks off");
  tx_hold_a: assert property (tx_analog.bias_on &&
    !tx_clock_enable |-> $stable(tx_hold)) else $error("tx moved");
  core_path_a: assert property (core_clock == (pll_output_connected ?
    $past(pll_clock_in) : $past(reference_clock_input)))
    else $error("core clock source wrong");
  pll_pd_a: assert property (pll_power_down |->
    !pll_output_connected) else $error("pll down but connected");
  cover property (pll_power_down);
  cover property (aux_interface_pin_b_oe && full_duplex);
  cover property (tx_analog.support_off);
endmodule
bind power_down_and_clock_out_control power_down_chk u_power_down_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr,
  .full_duplex, .reference_clock_input, .pll_clock_in,
  .aux_interface_pin_b_out, .aux_interface_pin_b_oe,
  .aux_interface_pin_c_out, .core_clock, .pll_power_down,
  .pll_output_connected, .tx_hold, .tx_clock_enable, .tx_analog,
  .rx_clock_enable);
`default_nettype wire

// ===== baseband_model.sv
// Baseband side model: clock sources and transmit samples.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Model
module baseband_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Toward the block
  output logic reference_clock_input,
  output logic pll_clock_in,
  output logic pll_locked,
  output logic tx_valid,
  output power_down_pkg::tx_sample_t tx_sample
);
  logic [19:0] cnt_r;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cnt_r <= 20'h0_0000;
    else
      cnt_r <= cnt_r + 20'h0_0001;
  // The reference runs at the fastest rate, so it can replace the PLL.
  assign reference_clock_input = cnt_r[0];
  assign pll_clock_in = cnt_r[1];
  assign pll_locked = 1'b1;
  assign tx_valid = 1'b1;
  assign tx_sample = cnt_r[19:0];
endmodule
`default_nettype wire

// ===== power_down_and_clock_out_control_tb.sv
// Testbench for the power-down and clock-out control block.
`timescale 1ns/1ps
`default_nettype none
`include "power_down_map.svh"
// ==========================================================================
// Bench
module power_down_and_clock_out_control_tb;
  localparam logic [7:0] A_ICC = {`ICC_INDEX, 2'b00};
  localparam logic [7:0] A_PDC = {`PDC_INDEX, 2'b00};
  localparam logic [7:0] A_STS = {`STS_INDEX, 2'b00};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, full_duplex = 1'b0, rerr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdata, prdata;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, ref_clk, pll_clk, pll_locked, tx_valid;
  logic pin_b, pin_b_oe, pin_c, core_clock, pll_pd, pll_conn;
  logic tx_clk_en, rx_clk_en;
  power_down_pkg::tx_sample_t tx_sample, tx_hold, h;
  power_down_pkg::tx_analog_t tx_analog;
  int errors = 0, n_tests = 0, cyc = 0;
  always #50 pclk = ~pclk;
  // Clock levels as the block sampled them at the last edge.
  logic ref_q, pll_q;
  always @(posedge pclk)
  begin
    ref_q <= ref_clk;
    pll_q <= pll_clk;
  end
  baseband_model u_baseband_model (.pclk, .presetn,
    .reference_clock_input(ref_clk), .pll_clock_in(pll_clk),
    .pll_locked, .tx_valid, .tx_sample);
  power_down_and_clock_out_control u_power_down_and_clock_out_control (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .reference_clock_input(ref_clk),
    .pll_clock_in(pll_clk), .pll_locked, .full_duplex,
    .aux_interface_pin_b_out(pin_b), .aux_interface_pin_b_oe(pin_b_oe),
    .aux_interface_pin_c_out(pin_c), .core_clock,
    .pll_power_down(pll_pd), .pll_output_connected(pll_conn), .tx_valid,
    .tx_sample, .tx_hold, .tx_clock_enable(tx_clk_en), .tx_analog,
    .rx_clock_enable(rx_clk_en));
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      errors++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
    repeat (2) @(posedge pclk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'hf);
    chk(rdata, exp);
    chk(rerr, 1'b0);
  endtask
  task automatic t_reset();
    rd(A_ICC, 32'h0000_0000);
    rd(A_PDC, 32'h0000_0000);
    rd(A_STS, 32'h0000_008f);
    $display("t_reset done");
  endtask
  task automatic t_analog();
    for (int p = 0; p < 8; p++)
    begin
      wr(A_PDC, {24'h0, p[2:0], 5'h00});
      chk(tx_analog, {1'b1, p[2:0] == `TXA_ALL_OFF,
        p[2:0] == `TXA_ALL_OFF || p[2:0] == `TXA_B_OFF,
        p[2:0] == `TXA_ALL_OFF || p[2:0] == `TXA_A_OFF});
    end
    $display("t_analog done");
  endtask
  task automatic t_txd();
    wr(A_PDC, 32'h0000_0010);
    chk(tx_clk_en, 1'b0);
    h = tx_hold;
    repeat (5) @(posedge pclk);
    #1;
    chk(tx_hold, h);
    wr(A_PDC, 32'h0000_0000);
    chk(tx_hold, tx_sample - 20'h1);
    $display("t_txd done");
  endtask
  task automatic t_pll();
    for (int v = 0; v < 8; v++)
    begin
      wr(A_PDC, {28'h0, v[2:0], 1'b0});
      chk(rx_clk_en, !v[2]);
      chk(pll_pd, v[1]);
      chk(pll_conn, v[1:0] == 2'b00);
      chk(core_clock, (v[1:0] == 2'b00) ? pll_q : ref_q);
      rd(A_STS, {24'h0, 4'h8, !v[2], 1'b1, v[1:0] == 2'b00, !v[1]});
    end
    $display("t_pll done");
  endtask
  task automatic t_clk();
    for (int f = 0; f < 2; f++)
    begin
      @(posedge pclk);
      full_duplex <= f[0];
      wr(A_ICC, 32'h0000_0006);
      chk(pin_b_oe, 1'b1);
      chk(pin_b, core_clock ^ f[0]);
      chk(pin_c, !core_clock);
    end
    wr(A_ICC, 32'h0000_0000);
    chk(pin_b_oe, 1'b0);
    chk(pin_c, core_clock);
    $display("t_clk done");
  endtask
  task automatic t_err();
    apb(1'b0, 8'h10, 32'h0, 4'hf);
    chk(rerr, 1'b1);
    apb(1'b1, A_STS, 32'h0, 4'hf);
    chk(rerr, 1'b1);
    apb(1'b1, A_PDC, 32'h0000_0010, 4'h0);
    rd(A_PDC, 32'h0000_000e);
    $display("t_err done");
  endtask
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_analog();
    t_txd();
    t_pll();
    t_clk();
    t_err();
    test_done();
  end
endmodule
`default_nettype wire
